// File: dv/asc_host.sv
/*
 * Behavioural host on the serial register link.
 * Shifts one frame MSB first and returns what miso carried; the link
 * clock stands low between frames.
 */
`timescale 1ns/1ps
module asc_host (
  output logic link_clk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Gap after each frame lets the reply settle before the next one
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    cs_n = 1'b0;
    for (int j = 1; j <= 16; j++) begin
      mosi = w[16 - j];
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
      r[16 - j] = miso_oe_n ? 1'bx : miso;
    end
    #20 cs_n = 1'b1;
    // Released line toggles so a stale bit is never mistaken for data
    mosi = ~mosi;
    #200;
  endtask
endmodule

// File: dv/asc_regs_chk.sv
/*
 * Core-side assertions for the control/status bank.
 * Bound to asc_regs from the testbench top; sees its ports only.
 */
`timescale 1ns/1ps
module asc_regs_chk
  import asc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic miso_oe_n,
  input wire asc_sense_t sense,
  input wire asc_req_t req
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_margin_excl; !(req.margin_lo && req.margin_hi); endproperty
  a_margin_excl: assert property (p_margin_excl) else $error("two margins");
  property p_margin_lock; $rose(req.margin_hi) |-> $past(sense.unlocked, 2); endproperty
  a_margin_lock: assert property (p_margin_lock) else $error("margin locked");
  property p_margin_hold; req.margin_hi |=> req.margin_hi; endproperty
  a_margin_hold: assert property (p_margin_hold) else $error("margin lost");
  property p_turns_pulse; req.turns_reset |=> !req.turns_reset; endproperty
  a_turns_pulse: assert property (p_turns_pulse) else $error("turns long");
  property p_reload_lock; req.reload |-> $past(sense.unlocked); endproperty
  a_reload_lock: assert property (p_reload_lock) else $error("reload locked");
  property p_hard_lock; req.hard_reset |-> $past(sense.unlocked); endproperty
  a_hard_lock: assert property (p_hard_lock) else $error("hard rst locked");
  property p_one_action;
    $onehot0({req.turns_reset, req.reload, req.hard_reset, req.logic_check_go});
  endproperty
  a_one_action: assert property (p_one_action) else $error("two actions");
  property p_ext_pulse; req.ext_read_start |=> !req.ext_read_start; endproperty
  a_ext_pulse: assert property (p_ext_pulse) else $error("ext start long");
  property p_oe_idle; cs_n [*4] |-> miso_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven idle");
endmodule

// File: dv/asc_regs_tb.sv
/*
 * Self-checking bench for asc_regs: actions, wipes, extended read and
 * random sense words. Needs asc_pkg, asc_host and asc_regs_chk.
 */
`timescale 1ns/1ps
module asc_regs_tb import asc_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic link_clk, cs_n, mosi, miso, miso_oe_n;
  asc_sense_t sense = '0;
  asc_done_t done = '0;
  asc_req_t req;
  int bad_count = 0;
  int checks_done = 0;
  int pc[10];
  int base[10];
  integer seed = 32'h89CFC956;
  logic [15:0] r;

  always #5 clock = ~clock;
  always @(posedge clock) for (int i = 0; i < 10; i++) pc[i] += req[i];

  asc_regs asc_regs_inst (.clock(clock), .rst(rst), .link_clk(link_clk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n), .sense(sense), .done(done), .req(req));
  asc_host asc_host_inst (.link_clk(link_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n));

  task automatic chk(input logic [15:0] got, exp, m, input string what);
    checks_done++;
    if ((got & m) !== (exp & m)) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    asc_host_inst.frame({2'b01, a, d}, r);
  endtask
  task automatic rd(input logic [5:0] a);
    asc_host_inst.frame({2'b00, a, 8'h00}, r);
    asc_host_inst.frame(16'h0000, r);
  endtask
  task automatic pul(input int k, input int n, input string what);
    chk(16'(pc[k] - base[k]), 16'(n), 16'hFFFF, what);
  endtask
  task automatic fin(input asc_done_t d);
    @(negedge clock);
    done = d;
    @(negedge clock);
    done = '0;
  endtask
  task automatic unl(input logic u);
    @(negedge clock);
    sense.unlocked = u;
  endtask
  function automatic logic [15:0] ang_word(asc_sense_t s);
    logic ef;
    logic uv;
    logic [15:0] w;
    ef = s.fault_unmasked | s.caution_unmasked;
    uv = (s.supply_low_flag & ~s.supply_mask) | (s.regulator_low_flag & ~s.regulator_mask);
    w = {1'b0, ef, uv, 1'b0, s.angle};
    // Parity bit makes the count of ones in the whole word odd
    w[12] = ~^w;
    return w;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    rd(ASC_STA_HI);
    chk(r, 16'h8002, 16'hF033, "boot status");
    sense.pll_locked = 1'b1;
    fin(5'h10);
    rd(ASC_STA_HI);
    chk(r, 16'h0011, 16'h0013, "booted");
    base = pc;
    wr(ASC_CTRL_HI, 8'h40);
    rd(ASC_CTRL_HI);
    chk(r, 16'h4000, 16'hFFFF, "select held");
    wr(ASC_CTRL_LO, ASC_KEY_TURNS);
    pul(9, 1, "turns");
    rd(ASC_CTRL_HI);
    chk(r, 16'h0000, 16'hFFFF, "select back");
    rd(ASC_STA_HI);
    chk(r, 16'h0020, 16'h0020, "turns finished");
    $display("test turns done");
    base = pc;
    wr(ASC_CTRL_HI, 8'h50);
    wr(ASC_CTRL_LO, ASC_KEY_RELOAD);
    pul(8, 0, "locked reload");
    unl(1'b1);
    wr(ASC_CTRL_HI, 8'h50);
    wr(ASC_CTRL_LO, ASC_KEY_RELOAD);
    pul(8, 1, "reload");
    rd(ASC_STA_HI);
    chk(r, 16'h0000, 16'h0020, "reload running");
    fin(5'h08);
    rd(ASC_STA_HI);
    chk(r, 16'h0020, 16'h0020, "reload finished");
    $display("test reload done");
    for (int c = 9; c <= 11; c++) begin
      base = pc;
      wr(ASC_CTRL_HI, {4'(c), 4'h0});
      wr(ASC_CTRL_LO, ASC_KEY_TURNS);
      wr(ASC_CTRL_LO, ASC_KEY_TEST);
      pul(6, c & 1, "field go");
      pul(5, (c >> 1) & 1, "logic go");
      rd(ASC_STA_HI);
      chk(r, 16'((c & 3) << 2), 16'h002C, "tests running");
      fin({2'b00, 1'(c), 1'(c >> 1), 1'b0});
      rd(ASC_STA_HI);
      chk(r, 16'h0020, 16'h002C, "tests over");
    end
    $display("test self-checks done");
    base = pc;
    wr(ASC_CTRL_HI, 8'h07);
    pul(2, 1, "wipe fault");
    pul(1, 1, "wipe caution");
    rd(ASC_STA_HI);
    chk(r, 16'h0000, 16'h0030, "finished wiped");
    rd(ASC_CTRL_HI);
    chk(r, 16'h0000, 16'h0700, "wipe bits");
    base = pc;
    wr(ASC_ERCS_HI, 8'h80);
    pul(0, 1, "ext start");
    rd(ASC_ERCS_HI);
    chk(r, 16'h0100, 16'h8101, "ext busy");
    fin(5'h01);
    rd(ASC_ERCS_HI);
    chk(r, 16'h0001, 16'h8101, "ext done");
    $display("test wipe and ext done");
    for (int i = 0; i < 7; i++) begin
      @(negedge clock);
      sense = (i == 0) ? '1 : 24'($random(seed));
      rd(ASC_ANG_HI);
      chk(r, ang_word(sense), 16'hFFFF, "angle");
      rd(ASC_STA_HI);
      chk(r, {6'h20, sense.die_id, sense.spin_direction & sense.hyst_en, 7'h00}, 16'hFF80,
        "status id");
    end
    $display("test random done");
    unl(1'b1);
    base = pc;
    wr(ASC_CTRL_HI, 8'h70);
    wr(ASC_CTRL_LO, ASC_KEY_HARD_RST);
    pul(7, 1, "hard reset");
    rd(ASC_STA_HI);
    chk(r, 16'h0002, 16'h0012, "reboot");
    fin(5'h10);
    unl(1'b0);
    wr(ASC_CTRL_HI, 8'h10);
    rd(ASC_CTRL_HI);
    chk(r, 16'h0000, 16'hF000, "locked margin");
    unl(1'b1);
    wr(ASC_CTRL_HI, 8'h10);
    rd(ASC_CTRL_HI);
    chk({15'h0, req.margin_lo}, 16'h0001, 16'hFFFF, "margin lo level");
    unl(1'b1);
    wr(ASC_CTRL_HI, 8'h20);
    rd(ASC_CTRL_HI);
    chk(r, 16'h2000, 16'hF000, "margin held");
    chk({15'h0, req.margin_hi}, 16'h0001, 16'hFFFF, "margin level");
    $display("test reset and margin done");
    complete_run;
  end

  initial begin
    #400000;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    complete_run;
  end
endmodule

bind asc_regs asc_regs_chk asc_regs_chk_inst (.clock(clock), .rst(rst), .cs_n(cs_n),
  .miso_oe_n(miso_oe_n), .sense(sense), .req(req));

// File: hw/asc_regs.sv
/*
 * Control, angle and status register bank with its serial register port.
 * Assumes sensing, memory and self-test logic on the core clock supply the
 * sense and done inputs, and a host drives cs_n, link_clk and mosi.
 */
`timescale 1ns/1ps
module asc_regs
  import asc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  input wire asc_sense_t sense,
  input wire asc_done_t done,
  output asc_req_t req
);

  // ****************************************************************
  // Link side: frame capture and reply shifting
  // ****************************************************************
  logic [3:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic miso_q;
  logic [15:0] frame_q;
  logic frame_tgl_q;
  logic [15:0] reply_q;

  // Chip select clears the frame position, so a stopped clock cannot
  // leave a half frame behind for the next one.
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 4'h0;
      shift_q <= ASC_WORD_RST;
      miso_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      shift_q <= {shift_q[14:0], mosi};
      miso_q <= reply_q[4'hF - bit_cnt_q];
    end
  end

  // The toggle must start known, or the core never sees a frame; rst is
  // released while the link clock stands still between frames.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      frame_q <= ASC_WORD_RST;
      frame_tgl_q <= 1'b0;
    end else if (!cs_n && bit_cnt_q == 4'hF) begin
      frame_q <= {shift_q[14:0], mosi};
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  assign miso = miso_q;

  // ****************************************************************
  // Crossing into the core clock
  // ****************************************************************
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic cs_s1_q, cs_s2_q;
  logic oe_n_q;
  logic frame_new;

  always_ff @(posedge clock) begin
    if (rst) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      tgl_s1_q <= frame_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      oe_n_q <= cs_s2_q;
    end
  end

  assign miso_oe_n = oe_n_q;
  // The frame word holds still for 15 link edges after its toggle and changes on the 16th.
  assign frame_new = tgl_s2_q ^ tgl_s3_q;

  logic wr_hit;
  logic [5:0] fr_addr;
  logic [7:0] fr_data;
  assign fr_addr = frame_q[ASC_FR_ADDR_LSB +: ASC_AW];
  assign fr_data = frame_q[7:0];
  assign wr_hit = frame_new && !frame_q[ASC_FR_ERR_BIT] && frame_q[ASC_FR_WR_BIT];

  function automatic logic wr_at(input logic [5:0] a);
    wr_at = wr_hit && fr_addr == a;
  endfunction

  // ****************************************************************
  // Action sequencing
  // ****************************************************************
  typedef enum logic [2:0] {
    ASC_IDLE,
    ASC_BOOT,
    ASC_RELOAD,
    ASC_TEST
  } asc_state_t;

  asc_state_t state_q;
  logic [3:0] sel_q;
  logic fin_q, boot_fin_q, boot_busy_q;
  logic field_run_q, logic_run_q;
  logic trig, need_unlock, act_ok, act_end;
  logic [7:0] key;

  assign trig = wr_at(ASC_CTRL_LO) && state_q == ASC_IDLE;

  always_comb begin
    key = 8'h00;
    need_unlock = 1'b0;
    case (sel_q)
      ASC_SEL_TURNS: key = ASC_KEY_TURNS;
      ASC_SEL_RELOAD: begin
        key = ASC_KEY_RELOAD;
        need_unlock = 1'b1;
      end
      ASC_SEL_HARD_RST: begin
        key = ASC_KEY_HARD_RST;
        need_unlock = 1'b1;
      end
      ASC_SEL_FIELD, ASC_SEL_LOGIC, ASC_SEL_BOTH: key = ASC_KEY_TEST;
      default: key = 8'h00;
    endcase
  end

  // A wrong key, an idle code or, for reload and hard reset, a locked part leave everything alone.
  assign act_ok = trig && key != 8'h00 && fr_data == key
                  && (!need_unlock || sense.unlocked);

  always_comb begin
    act_end = 1'b0;
    case (state_q)
      ASC_IDLE: act_end = act_ok && sel_q == ASC_SEL_TURNS;
      ASC_RELOAD: act_end = done.reload;
      ASC_TEST: act_end = (!field_run_q || done.field_check)
                          && (!logic_run_q || done.logic_check);
      default: act_end = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ASC_BOOT;
    end else begin
      case (state_q)
        ASC_IDLE: begin
          if (act_ok && sel_q == ASC_SEL_RELOAD) begin
            state_q <= ASC_RELOAD;
          end else if (act_ok && sel_q == ASC_SEL_HARD_RST) begin
            state_q <= ASC_BOOT;
          end else if (act_ok && key == ASC_KEY_TEST) begin
            state_q <= ASC_TEST;
          end
        end
        ASC_BOOT: if (done.boot) state_q <= ASC_IDLE;
        ASC_RELOAD, ASC_TEST: if (act_end) state_q <= ASC_IDLE;
        default: state_q <= ASC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sel_q <= ASC_SEL_NONE;
    end else if (act_end && state_q != ASC_IDLE) begin
      sel_q <= ASC_SEL_NONE;
    end else if (act_ok && sel_q == ASC_SEL_HARD_RST) begin
      sel_q <= ASC_SEL_NONE;
    end else if (act_end) begin
      sel_q <= ASC_SEL_NONE;
    end else if (wr_at(ASC_CTRL_HI) && state_q == ASC_IDLE) begin
      // Margin codes are only taken while unlocked.
      if (fr_data[7:4] == ASC_SEL_MARGIN_LO || fr_data[7:4] == ASC_SEL_MARGIN_HI) begin
        if (sense.unlocked) sel_q <= fr_data[7:4];
      end else begin
        sel_q <= fr_data[7:4];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      field_run_q <= 1'b0;
      logic_run_q <= 1'b0;
    end else if (state_q == ASC_IDLE) begin
      field_run_q <= act_ok && (sel_q == ASC_SEL_FIELD || sel_q == ASC_SEL_BOTH);
      logic_run_q <= act_ok && (sel_q == ASC_SEL_LOGIC || sel_q == ASC_SEL_BOTH);
    end else begin
      if (done.field_check) field_run_q <= 1'b0;
      if (done.logic_check) logic_run_q <= 1'b0;
    end
  end

  // Completion beats a simultaneous wipe, so no finish is lost.
  always_ff @(posedge clock) begin
    if (rst) begin
      fin_q <= 1'b0;
      boot_fin_q <= 1'b0;
      boot_busy_q <= 1'b1;
    end else begin
      if (act_end) begin
        fin_q <= 1'b1;
      end else if (act_ok) begin
        fin_q <= 1'b0;
      end else if (wr_at(ASC_CTRL_HI) && fr_data[ASC_WIPE_DONE_BIT - 8]) begin
        fin_q <= 1'b0;
      end
      if (state_q == ASC_BOOT && done.boot) begin
        boot_fin_q <= 1'b1;
      end else if (wr_at(ASC_CTRL_HI) && fr_data[ASC_WIPE_DONE_BIT - 8]) begin
        boot_fin_q <= 1'b0;
      end else if (act_ok && sel_q == ASC_SEL_HARD_RST) begin
        boot_fin_q <= 1'b0;
      end
      if (act_ok && sel_q == ASC_SEL_HARD_RST) begin
        boot_busy_q <= 1'b1;
      end else if (state_q == ASC_BOOT && done.boot) begin
        boot_busy_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Extended read handshake
  // ****************************************************************
  logic xr_busy_q, xr_done_q, xr_go;
  assign xr_go = wr_at(ASC_ERCS_HI) && fr_data[ASC_GO_BIT - 8];

  always_ff @(posedge clock) begin
    if (rst) begin
      xr_busy_q <= 1'b0;
      xr_done_q <= 1'b0;
    end else if (xr_go) begin
      xr_busy_q <= 1'b1;
      xr_done_q <= 1'b0;
    end else if (xr_busy_q && done.ext_read) begin
      xr_busy_q <= 1'b0;
      xr_done_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Requests to the sensing, memory and test logic
  // ****************************************************************
  logic wipe_f, wipe_c;
  assign wipe_f = wr_at(ASC_CTRL_HI) && fr_data[ASC_WIPE_FAULT_BIT - 8];
  assign wipe_c = wr_at(ASC_CTRL_HI) && fr_data[ASC_WIPE_CAUTION_BIT - 8];

  always_ff @(posedge clock) begin
    if (rst) begin
      req <= '0;
    end else begin
      req.turns_reset <= act_ok && sel_q == ASC_SEL_TURNS;
      req.reload <= act_ok && sel_q == ASC_SEL_RELOAD;
      req.hard_reset <= act_ok && sel_q == ASC_SEL_HARD_RST;
      req.field_check_go <= act_ok && (sel_q == ASC_SEL_FIELD || sel_q == ASC_SEL_BOTH);
      req.logic_check_go <= act_ok && (sel_q == ASC_SEL_LOGIC || sel_q == ASC_SEL_BOTH);
      req.margin_lo <= sel_q == ASC_SEL_MARGIN_LO;
      req.margin_hi <= sel_q == ASC_SEL_MARGIN_HI;
      // Only flags already read are dropped; the fault logic keeps the rest.
      req.wipe_fault <= wipe_f;
      req.wipe_caution <= wipe_c;
      req.ext_read_start <= xr_go;
    end
  end

  // ****************************************************************
  // Read words and reply for the next frame
  // ****************************************************************
  logic ef, uv;
  logic [15:0] ang_w, sta_w;

  assign ef = sense.fault_unmasked | sense.caution_unmasked;
  assign uv = (sense.supply_low_flag & ~sense.supply_mask)
              | (sense.regulator_low_flag & ~sense.regulator_mask);
  assign ang_w = {1'b0, ef, uv, ~^{ef, uv, sense.angle}, sense.angle};
  assign sta_w = {ASC_STA_TAG, 2'b00, sense.die_id,
                  sense.spin_direction & sense.hyst_en, 1'b0,
                  fin_q, boot_fin_q, logic_run_q, field_run_q,
                  boot_busy_q,
                  sense.pll_locked & boot_fin_q & ~boot_busy_q};

  function automatic logic [15:0] read_word(input logic [5:0] a);
    case ({a[5:1], 1'b0})
      ASC_ERCS_HI: read_word = 16'h0000 | (16'(xr_busy_q) << ASC_BUSY_BIT)
                               | (16'(xr_done_q) << ASC_DONE_BIT);
      ASC_CTRL_HI: read_word = {sel_q, 12'h000};
      ASC_ANG_HI: read_word = ang_w;
      ASC_STA_HI: read_word = sta_w;
      default: read_word = 16'h0000;
    endcase
  endfunction

  always_ff @(posedge clock) begin
    if (rst) begin
      reply_q <= ASC_WORD_RST;
    end else if (frame_new && !frame_q[ASC_FR_ERR_BIT]) begin
      reply_q <= read_word(fr_addr);
    end
  end

endmodule

// File: include/asc_pkg.sv
/*
 * Constants and carrier types for the angle sensor control/status bank.
 * Assumes a 6-bit byte address space reached over the serial register port.
 */
package asc_pkg;

  // ****************************************************************
  // Register byte addresses (a word is addressed by its upper byte)
  // ****************************************************************
  localparam int ASC_AW = 6;
  localparam logic [5:0] ASC_ERCS_HI = 6'h0C;
  localparam logic [5:0] ASC_CTRL_HI = 6'h1E;
  localparam logic [5:0] ASC_CTRL_LO = 6'h1F;
  localparam logic [5:0] ASC_ANG_HI = 6'h20;
  localparam logic [5:0] ASC_STA_HI = 6'h22;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ASC_GO_BIT = 15;
  localparam int ASC_BUSY_BIT = 8;
  localparam int ASC_DONE_BIT = 0;
  localparam int ASC_SEL_LSB = 12;
  localparam int ASC_WIPE_DONE_BIT = 10;
  localparam int ASC_WIPE_CAUTION_BIT = 9;
  localparam int ASC_WIPE_FAULT_BIT = 8;
  localparam int ASC_FR_ERR_BIT = 15;
  localparam int ASC_FR_WR_BIT = 14;
  localparam int ASC_FR_ADDR_LSB = 8;
  localparam int ASC_FRAME_BITS = 16;

  // ****************************************************************
  // Action codes, trigger keys, tags, reset values
  // ****************************************************************
  localparam logic [3:0] ASC_SEL_NONE = 4'h0;
  localparam logic [3:0] ASC_SEL_MARGIN_LO = 4'h1;
  localparam logic [3:0] ASC_SEL_MARGIN_HI = 4'h2;
  localparam logic [3:0] ASC_SEL_TURNS = 4'h4;
  localparam logic [3:0] ASC_SEL_RELOAD = 4'h5;
  localparam logic [3:0] ASC_SEL_HARD_RST = 4'h7;
  localparam logic [3:0] ASC_SEL_FIELD = 4'h9;
  localparam logic [3:0] ASC_SEL_LOGIC = 4'hA;
  localparam logic [3:0] ASC_SEL_BOTH = 4'hB;
  localparam logic [7:0] ASC_KEY_TURNS = 8'h46;
  localparam logic [7:0] ASC_KEY_RELOAD = 8'hA5;
  localparam logic [7:0] ASC_KEY_HARD_RST = 8'h5A;
  localparam logic [7:0] ASC_KEY_TEST = 8'hB9;
  localparam logic [3:0] ASC_STA_TAG = 4'h8;
  localparam logic [15:0] ASC_WORD_RST = 16'h0000;

  typedef struct packed {
    logic [11:0] angle;
    logic [1:0] die_id;
    logic pll_locked;
    logic spin_direction;
    logic hyst_en;
    logic supply_low_flag;
    logic regulator_low_flag;
    logic supply_mask;
    logic regulator_mask;
    logic fault_unmasked;
    logic caution_unmasked;
    logic unlocked;
  } asc_sense_t;

  typedef struct packed {
    logic boot;
    logic reload;
    logic field_check;
    logic logic_check;
    logic ext_read;
  } asc_done_t;

  typedef struct packed {
    logic turns_reset;
    logic reload;
    logic hard_reset;
    logic field_check_go;
    logic logic_check_go;
    logic margin_lo;
    logic margin_hi;
    logic wipe_fault;
    logic wipe_caution;
    logic ext_read_start;
  } asc_req_t;

endpackage
